// ---- rtcia_cfg.svh ----
// Constants of the RTC interrupt routing and alarm date block.
// Assumes it is included by bare name by every file that decodes registers or times the pulse.
`ifndef RTCIA_CFG_SVH
`define RTCIA_CFG_SVH

// Register bus geometry and register offsets.
`define RTCIA_ADDR_W 20
`define RTCIA_OFS_FLAGS 20'hFFFF0
`define RTCIA_OFS_ALARM_DATE 20'hFFFF5
`define RTCIA_OFS_INT_CTRL 20'hFFFF6
`define RTCIA_READ_ZERO 8'h00

// Interrupt control fields; the flags register uses the same three source positions.
`define RTCIA_BIT_WDOG 7
`define RTCIA_BIT_ALARM 6
`define RTCIA_BIT_PFAIL 5
`define RTCIA_BIT_RSV4 4
`define RTCIA_BIT_POL_HIGH 3
`define RTCIA_BIT_PULSE 2
`define RTCIA_BIT_RSV1 1
`define RTCIA_BIT_RSV0 0
`define RTCIA_CTRL_WR_MASK 8'hEC
`define RTCIA_FLAGS_MASK 8'hE0

// Alarm date fields.
`define RTCIA_DATE_MASK_BIT 7
`define RTCIA_DATE_ZERO_BIT 6
`define RTCIA_TENS_HI 5
`define RTCIA_TENS_LO 4
`define RTCIA_UNITS_HI 3
`define RTCIA_UNITS_LO 0
`define RTCIA_DATE_WR_MASK 8'hBF

// Reset values.
`define RTCIA_CTRL_RST 8'h00
`define RTCIA_DATE_RST 8'h00
`define RTCIA_FLAGS_RST 8'h00

// Interrupt pulse length, given in milliseconds, and the clock rate.
`define RTCIA_PULSE_MS 200
`define RTCIA_CLK_HZ 10000000
`define RTCIA_MS_PER_S 1000
`define RTCIA_PULSE_CYCLES (`RTCIA_PULSE_MS * (`RTCIA_CLK_HZ / `RTCIA_MS_PER_S))
`define RTCIA_PULSE_CNT_W 22
// Widest pulse counter that still fits a plain int in the length checks.
`define RTCIA_CNT_W_MAX 31

`endif

// ---- rtcia_pkg.sv ----
// Types shared by the RTC interrupt routing and alarm date block.
// Assumes nothing of its surroundings.
package rtcia_pkg;

  // One register byte.
  typedef logic [7:0] rtcia_byte_t;

  // States of the interrupt pulse timer.
  typedef enum logic [0:0] {
    RTCIA_PT_IDLE = 1'b0,
    RTCIA_PT_RUN = 1'b1
  } rtcia_pulse_state_e;

endpackage

// ---- rtcia_pulse_timer.sv ----
// Retriggerable one-shot that holds the interrupt active for a fixed number of cycles.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "rtcia_cfg.svh"

module rtcia_pulse_timer #(
  parameter int unsigned CYCLES = `RTCIA_PULSE_CYCLES,
  parameter int unsigned CNT_W = `RTCIA_PULSE_CNT_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic trigger,
  input wire logic abort,
  output logic active
);

  rtcia_pkg::rtcia_pulse_state_e state_ff;
  logic [CNT_W-1:0] count_ff;

  // Refuses a length that the counter cannot hold.
  if (CYCLES < 1 || CNT_W > `RTCIA_CNT_W_MAX || CYCLES > (1 << CNT_W)) begin : g_bad_len
    $error("pulse length does not fit the counter");
  end

  // A trigger always restarts the full length, so a new event stretches the pulse.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= rtcia_pkg::RTCIA_PT_IDLE;
      count_ff <= '0;
    end else if (trigger) begin
      state_ff <= rtcia_pkg::RTCIA_PT_RUN;
      count_ff <= CNT_W'(CYCLES - 1);
    end else if (abort) begin
      state_ff <= rtcia_pkg::RTCIA_PT_IDLE;
      count_ff <= '0;
    end else begin
      unique case (state_ff)
        rtcia_pkg::RTCIA_PT_IDLE: begin
          count_ff <= '0;
        end
        rtcia_pkg::RTCIA_PT_RUN: begin
          if (count_ff == '0) begin
            state_ff <= rtcia_pkg::RTCIA_PT_IDLE;
          end else begin
            count_ff <= count_ff - 1'b1;
          end
        end
      endcase
    end
  end

  // The pulse is active for exactly as long as the timer runs.
  assign active = (state_ff == rtcia_pkg::RTCIA_PT_RUN);

endmodule

// ---- rtcia_irq_alarm.sv ----
// Interrupt routing, output shaping and alarm date compare of the real time clock.
// Assumes event strobes are one cycle long and synchronous to sys_clk, and that the
// date counter, hours and minutes compare and watchdog live outside this module.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "rtcia_cfg.svh"

// Operation
// [R1] With the watchdog interrupt enable set, a watchdog timeout raises the interrupt and sets its flag.
// [R2] With the watchdog interrupt enable clear, a watchdog timeout only sets its flag.
// [R3] An alarm match sets its flag and raises the interrupt only when the alarm enable is set.
// [R4] A power-fail detection sets its flag and raises the interrupt only when its enable is set.
// [R5] Bits 4, 1 and 0 of the interrupt control register always hold zero.
// [R6] With the polarity bit set, the interrupt pin is driven high while active.
// [R7] With the polarity bit clear, the pin is open drain, pulled low while active and released otherwise.
// [R8] With the pulse bit set, each routed event makes the pin active for a pulse of about 200 ms.
// [R9] With the pulse bit clear, the pin stays active until the flags register is read.
// [R10] The alarm date register holds the mask at bit 7, zero at bit 6, tens at 5..4 and units at 3..0.
// [R11] With the date mask clear, the stored date takes part in the alarm comparison.
// [R12] With the date mask set, the date is ignored and the alarm may match on any day.
// [R13] The alarm date is held in BCD and compared digit by digit with the running date.
module rtcia_irq_alarm #(
  parameter int unsigned PULSE_CYCLES = `RTCIA_PULSE_CYCLES,
  parameter int unsigned PULSE_CNT_W = `RTCIA_PULSE_CNT_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [`RTCIA_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic wdogTimeoutStb,
  input wire logic alarmCheckStb,
  input wire logic alarmTimeMatch,
  input wire logic [1:0] curDateTens,
  input wire logic [3:0] curDateUnits,
  input wire logic powerFailStb,
  output logic irqPinOut,
  output logic irqPinOutEn_n,
  output logic intReq
);

  rtcia_pkg::rtcia_byte_t intCtrl_ff;
  rtcia_pkg::rtcia_byte_t alarmDate_ff;
  rtcia_pkg::rtcia_byte_t flags_ff;
  rtcia_pkg::rtcia_byte_t regRdData_ff;
  rtcia_pkg::rtcia_byte_t nxt_rdData;
  rtcia_pkg::rtcia_byte_t eventVec;
  rtcia_pkg::rtcia_byte_t routedVec;
  logic levelPending_ff;
  logic irqPinOut_ff;
  logic irqPinOutEn_n_ff;
  logic intReq_ff;
  logic wrCtrl;
  logic wrDate;
  logic wrFlags;
  logic rdFlags;
  logic dateEqual;
  logic alarmEvent;
  logic anyRouted;
  logic pulseMode;
  logic polHigh;
  logic pulseActive;
  logic irqActive;

  // Refuses a pulse length or counter width that the pulse logic cannot time.
  if (PULSE_CYCLES < 1 || PULSE_CNT_W > `RTCIA_CNT_W_MAX) begin : g_bad_param
    $error("pulse parameters out of range");
  end

  // Address decode of the three registers.
  assign wrCtrl = regWrStb && (regAddr == `RTCIA_OFS_INT_CTRL);
  assign wrDate = regWrStb && (regAddr == `RTCIA_OFS_ALARM_DATE);
  assign wrFlags = regWrStb && (regAddr == `RTCIA_OFS_FLAGS);
  assign rdFlags = regRdStb && (regAddr == `RTCIA_OFS_FLAGS);

  // Interrupt control register; reserved bits are dropped on write.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      intCtrl_ff <= `RTCIA_CTRL_RST;
    end else if (wrCtrl) begin
      intCtrl_ff <= regWrData & `RTCIA_CTRL_WR_MASK; // [R5]
    end
  end

  // Alarm date register; bit 6 can never be written to one.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alarmDate_ff <= `RTCIA_DATE_RST;
    end else if (wrDate) begin
      alarmDate_ff <= regWrData & `RTCIA_DATE_WR_MASK; // [R10]
    end
  end

  assign pulseMode = intCtrl_ff[`RTCIA_BIT_PULSE];
  assign polHigh = intCtrl_ff[`RTCIA_BIT_POL_HIGH];

  // Digit-wise BCD compare of tens and units, skipped when the date mask is set.
  assign dateEqual = (alarmDate_ff[`RTCIA_TENS_HI:`RTCIA_TENS_LO] == curDateTens) && // [R13]
    (alarmDate_ff[`RTCIA_UNITS_HI:`RTCIA_UNITS_LO] == curDateUnits); // [R11]
  assign alarmEvent = alarmCheckStb && alarmTimeMatch &&
    (alarmDate_ff[`RTCIA_DATE_MASK_BIT] || dateEqual); // [R12]

  // Source events gathered at the flag positions, then gated by the enables.
  always_comb begin
    eventVec = `RTCIA_READ_ZERO;
    eventVec[`RTCIA_BIT_WDOG] = wdogTimeoutStb;
    eventVec[`RTCIA_BIT_ALARM] = alarmEvent;
    eventVec[`RTCIA_BIT_PFAIL] = powerFailStb;
  end
  assign routedVec = eventVec & intCtrl_ff & `RTCIA_FLAGS_MASK; // [R1] [R3] [R4]
  assign anyRouted = |routedVec;

  // Sticky flags: every event sets its flag whatever the enable; writing one clears, set wins.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_ff <= `RTCIA_FLAGS_RST;
    end else begin
      flags_ff <= ((flags_ff & ~(wrFlags ? regWrData : `RTCIA_READ_ZERO)) | eventVec)
        & `RTCIA_FLAGS_MASK; // [R2]
    end
  end

  // Level mode: held until the flags are read; a routed event in the read cycle wins.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      levelPending_ff <= 1'b0;
    end else if (anyRouted && !pulseMode) begin
      levelPending_ff <= 1'b1;
    end else if (rdFlags || pulseMode) begin
      levelPending_ff <= 1'b0; // [R9]
    end
  end

  // Pulse mode: every routed event restarts a fixed-length pulse.
  rtcia_pulse_timer #(
    .CYCLES(PULSE_CYCLES),
    .CNT_W(PULSE_CNT_W)
  ) u_pulse (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .trigger(anyRouted && pulseMode), // [R8]
    .abort(!pulseMode),
    .active(pulseActive)
  );

  assign irqActive = pulseMode ? pulseActive : levelPending_ff;

  // Pin shaping: driven high, or open drain pulling low and otherwise released.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqPinOut_ff <= 1'b0;
      irqPinOutEn_n_ff <= 1'b1;
    end else if (polHigh) begin
      irqPinOut_ff <= irqActive; // [R6]
      irqPinOutEn_n_ff <= 1'b0;
    end else begin
      irqPinOut_ff <= 1'b0; // [R7]
      irqPinOutEn_n_ff <= !irqActive;
    end
  end

  // Internal level request: high while an enabled flag is set.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      intReq_ff <= 1'b0;
    end else begin
      intReq_ff <= |(flags_ff & intCtrl_ff & `RTCIA_FLAGS_MASK);
    end
  end

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    nxt_rdData = `RTCIA_READ_ZERO;
    unique case (regAddr)
      `RTCIA_OFS_INT_CTRL: nxt_rdData = intCtrl_ff;
      `RTCIA_OFS_ALARM_DATE: nxt_rdData = alarmDate_ff;
      `RTCIA_OFS_FLAGS: nxt_rdData = flags_ff;
      default: nxt_rdData = `RTCIA_READ_ZERO;
    endcase
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData_ff <= `RTCIA_READ_ZERO;
    end else if (regRdStb) begin
      regRdData_ff <= nxt_rdData;
    end else begin
      regRdData_ff <= `RTCIA_READ_ZERO;
    end
  end

  assign regRdData = regRdData_ff;
  assign irqPinOut = irqPinOut_ff;
  assign irqPinOutEn_n = irqPinOutEn_n_ff;
  assign intReq = intReq_ff;

  // Checks of the routing, the pin shaping and the alarm compare.
  property p_wdog_routed;
    @(posedge sys_clk) disable iff (sys_rst)
    (wdogTimeoutStb && intCtrl_ff[`RTCIA_BIT_WDOG] && !pulseMode)
      |=> (levelPending_ff && flags_ff[`RTCIA_BIT_WDOG]);
  endproperty
  a_wdog_routed: assert property (p_wdog_routed) // [R1]
    else $error("routed watchdog timeout did not raise the interrupt");

  property p_wdog_flag_only;
    @(posedge sys_clk) disable iff (sys_rst)
    (wdogTimeoutStb && !anyRouted && !levelPending_ff && !pulseMode && !wrCtrl)
      |=> (!levelPending_ff && flags_ff[`RTCIA_BIT_WDOG]);
  endproperty
  a_wdog_flag_only: assert property (p_wdog_flag_only) // [R2]
    else $error("unrouted watchdog timeout touched the interrupt");

  property p_alarm_route;
    @(posedge sys_clk) disable iff (sys_rst)
    (alarmEvent && intCtrl_ff[`RTCIA_BIT_ALARM] && !wrCtrl)
      |=> (irqActive && flags_ff[`RTCIA_BIT_ALARM]);
  endproperty
  a_alarm_route: assert property (p_alarm_route) // [R3]
    else $error("routed alarm match did not raise the interrupt");

  property p_pfail_route;
    @(posedge sys_clk) disable iff (sys_rst)
    (powerFailStb && intCtrl_ff[`RTCIA_BIT_PFAIL] && !wrCtrl)
      |=> (irqActive && flags_ff[`RTCIA_BIT_PFAIL]);
  endproperty
  a_pfail_route: assert property (p_pfail_route) // [R4]
    else $error("routed power fail did not raise the interrupt");

  property p_ctrl_reserved;
    @(posedge sys_clk) disable iff (sys_rst)
    wrCtrl |=> (intCtrl_ff[`RTCIA_BIT_RSV4] == 1'b0) && (intCtrl_ff[`RTCIA_BIT_RSV1] == 1'b0)
      && (intCtrl_ff[`RTCIA_BIT_RSV0] == 1'b0)
      && (intCtrl_ff[`RTCIA_BIT_WDOG:`RTCIA_BIT_PFAIL]
        == $past(regWrData[`RTCIA_BIT_WDOG:`RTCIA_BIT_PFAIL]));
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) // [R5]
    else $error("interrupt control reserved bits not zero");

  property p_pin_high;
    @(posedge sys_clk) disable iff (sys_rst)
    (polHigh && irqActive && !wrCtrl) |=> (irqPinOut && !irqPinOutEn_n);
  endproperty
  a_pin_high: assert property (p_pin_high) // [R6]
    else $error("active high interrupt pin not driven high");

  property p_pin_open_drain;
    @(posedge sys_clk) disable iff (sys_rst)
    (!polHigh && !wrCtrl) |=> (!irqPinOut && (irqPinOutEn_n == !$past(irqActive)));
  endproperty
  a_pin_open_drain: assert property (p_pin_open_drain) // [R7]
    else $error("open drain interrupt pin misdriven");

  property p_pulse_len;
    @(posedge sys_clk) disable iff (sys_rst)
    (anyRouted && pulseMode && !wrCtrl) ##1 (!wrCtrl) [*7] |-> pulseActive;
  endproperty
  a_pulse_len: assert property (p_pulse_len) // [R8]
    else $error("interrupt pulse ended too early");

  property p_level_release;
    @(posedge sys_clk) disable iff (sys_rst)
    (rdFlags && !anyRouted && !pulseMode) |=> !levelPending_ff;
  endproperty
  a_level_release: assert property (p_level_release) // [R9]
    else $error("flags read did not release the level interrupt");

  property p_level_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    (levelPending_ff && !rdFlags && !wrCtrl && !pulseMode) |=> levelPending_ff;
  endproperty
  a_level_hold: assert property (p_level_hold) // [R9]
    else $error("level interrupt dropped without a flags read");

  property p_date_zero;
    @(posedge sys_clk) disable iff (sys_rst)
    wrDate |=> (alarmDate_ff[`RTCIA_DATE_ZERO_BIT] == 1'b0)
      && (alarmDate_ff[`RTCIA_DATE_MASK_BIT] == $past(regWrData[`RTCIA_DATE_MASK_BIT]));
  endproperty
  a_date_zero: assert property (p_date_zero) // [R10]
    else $error("alarm date bit 6 not zero");

  property p_date_miss;
    @(posedge sys_clk) disable iff (sys_rst)
    (alarmCheckStb && alarmTimeMatch && !alarmDate_ff[`RTCIA_DATE_MASK_BIT] && !dateEqual
      && !flags_ff[`RTCIA_BIT_ALARM]) |=> !flags_ff[`RTCIA_BIT_ALARM];
  endproperty
  a_date_miss: assert property (p_date_miss) // [R11]
    else $error("alarm matched on a wrong date");

  property p_date_masked;
    @(posedge sys_clk) disable iff (sys_rst)
    (alarmCheckStb && alarmTimeMatch && alarmDate_ff[`RTCIA_DATE_MASK_BIT])
      |=> flags_ff[`RTCIA_BIT_ALARM];
  endproperty
  a_date_masked: assert property (p_date_masked) // [R12]
    else $error("masked date blocked the alarm");

  property p_date_bcd;
    @(posedge sys_clk) disable iff (sys_rst)
    (alarmCheckStb && alarmTimeMatch
      && (curDateTens == alarmDate_ff[`RTCIA_TENS_HI:`RTCIA_TENS_LO])
      && (curDateUnits == alarmDate_ff[`RTCIA_UNITS_HI:`RTCIA_UNITS_LO]))
      |=> flags_ff[`RTCIA_BIT_ALARM];
  endproperty
  a_date_bcd: assert property (p_date_bcd) // [R13]
    else $error("matching BCD date did not set the alarm flag");

  // Age of the running pulse since its last start, so an overlong pulse is caught.
  logic [PULSE_CNT_W:0] pulseAge_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pulseAge_ff <= '0;
    end else if (anyRouted && pulseMode) begin
      pulseAge_ff <= '0;
    end else if (pulseActive) begin
      pulseAge_ff <= pulseAge_ff + 1'b1;
    end
  end

  property p_pulse_max;
    @(posedge sys_clk) disable iff (sys_rst)
    pulseActive |-> (pulseAge_ff < (PULSE_CNT_W + 1)'(PULSE_CYCLES));
  endproperty
  a_pulse_max: assert property (p_pulse_max) // [R8]
    else $error("interrupt pulse lasted too long");

  property p_alarm_time_gate;
    @(posedge sys_clk) disable iff (sys_rst)
    (alarmCheckStb && !alarmTimeMatch && !flags_ff[`RTCIA_BIT_ALARM])
      |=> !flags_ff[`RTCIA_BIT_ALARM];
  endproperty
  a_alarm_time_gate: assert property (p_alarm_time_gate) // [R3]
    else $error("alarm flag set without a time match");

  property p_flag_set_wins;
    @(posedge sys_clk) disable iff (sys_rst)
    (wdogTimeoutStb && wrFlags && regWrData[`RTCIA_BIT_WDOG]) |=> flags_ff[`RTCIA_BIT_WDOG];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) // [R2]
    else $error("clearing write swallowed a watchdog timeout");

  // Main scenarios.
  c_pulse_irq: cover property (@(posedge sys_clk) disable iff (sys_rst)
    anyRouted && pulseMode ##1 pulseActive);
  c_level_release: cover property (@(posedge sys_clk) disable iff (sys_rst)
    levelPending_ff ##1 rdFlags ##1 !levelPending_ff);
  c_open_drain: cover property (@(posedge sys_clk) disable iff (sys_rst)
    !polHigh && !irqPinOutEn_n);
  c_masked_alarm: cover property (@(posedge sys_clk) disable iff (sys_rst)
    alarmEvent && alarmDate_ff[`RTCIA_DATE_MASK_BIT] && !dateEqual);

endmodule

// ---- rtcia_host_model.sv ----
// Host processor model: register bus master and the pulled-up interrupt line.
// Assumes one clock; bus calls are made right after a rising edge.
`timescale 1ns/1ps
`include "rtcia_cfg.svh"

module rtcia_host_model (
  input wire logic sys_clk,
  output logic [`RTCIA_ADDR_W-1:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrStb,
  output logic regRdStb,
  input wire logic irqPinOut,
  input wire logic irqPinOutEn_n,
  output logic irqLine
);
  // A released pin lets the board pull-up hold the line high.
  assign irqLine = irqPinOutEn_n ? 1'b1 : irqPinOut;

  // The bus idles with both strobes low from time zero.
  initial begin
    regAddr = '0;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end

  // One bus cycle: every signal is set once, then held over the sampling edge.
  task automatic bus(input logic w, input logic r, input logic [`RTCIA_ADDR_W-1:0] a,
                     input logic [7:0] d);
    regWrStb <= w;
    regRdStb <= r;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the interrupt routing and alarm date block.
// Assumes the host model is compiled first and a 10 MHz clock.
`timescale 1ns/1ps
`include "rtcia_cfg.svh"

module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst;
  logic [`RTCIA_ADDR_W-1:0] regAddr;
  logic [7:0] regWrData, regRdData, rnd, bitv;
  logic regWrStb, regRdStb, wdogTimeoutStb, alarmCheckStb, alarmTimeMatch, powerFailStb;
  logic irqPinOut, irqPinOutEn_n, intReq, irqLine, rdSeen;
  logic [1:0] curDateTens;
  logic [3:0] curDateUnits;
  logic [7:0] expQ[$];
  logic [7:0] dates[4] = '{8'h25, 8'h25, 8'h25, 8'hA5};
  logic [5:0] curs[4] = '{6'h25, 6'h15, 6'h24, 6'h31};
  logic [7:0] hits[4] = '{8'h40, 8'h00, 8'h00, 8'h40};
  int num_errors = 0;
  int compares = 0;
  int actCnt = 0;

  // The clock toggles every half period of 50 ns.
  always #50 sys_clk = ~sys_clk;

  rtcia_irq_alarm #(.PULSE_CYCLES(8), .PULSE_CNT_W(22)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .wdogTimeoutStb(wdogTimeoutStb), .alarmCheckStb(alarmCheckStb),
    .alarmTimeMatch(alarmTimeMatch), .curDateTens(curDateTens), .curDateUnits(curDateUnits),
    .powerFailStb(powerFailStb), .irqPinOut(irqPinOut), .irqPinOutEn_n(irqPinOutEn_n),
    .intReq(intReq)
  );

  rtcia_host_model host (
    .sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .irqPinOut(irqPinOut), .irqPinOutEn_n(irqPinOutEn_n),
    .irqLine(irqLine)
  );

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) host.bus(1'b0, 1'b0, regAddr, 8'h00);
  endtask

  task automatic wr(input logic [`RTCIA_ADDR_W-1:0] a, input logic [7:0] d);
    host.bus(1'b1, 1'b0, a, d);
    idle(1);
  endtask

  // A read notes its expected byte; the monitor compares it when the data stand.
  task automatic rd(input logic [`RTCIA_ADDR_W-1:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    host.bus(1'b0, 1'b1, a, 8'h00);
    idle(2);
  endtask

  // Checks pin enable, resolved line level and level request mid-cycle.
  task automatic pin(input logic enN, input logic lvl, input logic req);
    @(negedge sys_clk);
    cmp("pin enable line request", {5'h00, enN, lvl, req},
        {5'h00, irqPinOutEn_n, irqLine, intReq});
    @(posedge sys_clk);
  endtask

  // Pulses one event strobe for a single cycle, then lets the pin settle.
  task automatic fire(input int src);
    if (src == 0) wdogTimeoutStb <= 1'b1;
    else if (src == 1) alarmCheckStb <= 1'b1;
    else powerFailStb <= 1'b1;
    @(posedge sys_clk);
    wdogTimeoutStb <= 1'b0;
    alarmCheckStb <= 1'b0;
    powerFailStb <= 1'b0;
    idle(2);
  endtask

  // Read data are valid only in the cycle after the read strobe.
  always @(posedge sys_clk) rdSeen <= regRdStb;
  always @(negedge sys_clk) begin
    if (rdSeen) begin
      if (expQ.size() == 0) cmp("unexpected read", 8'h00, 8'hFF);
      else cmp("read data", expQ.pop_front(), regRdData);
    end
  end

  // Counts cycles in which the pin drives its active high level.
  always @(negedge sys_clk) if (irqPinOutEn_n === 1'b0 && irqPinOut === 1'b1) actCnt++;

  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    wdogTimeoutStb = 1'b0;
    alarmCheckStb = 1'b0;
    powerFailStb = 1'b0;
    alarmTimeMatch = 1'b0;
    curDateTens = 2'h0;
    curDateUnits = 4'h0;
    void'($urandom(21));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pin(1'b1, 1'b1, 1'b0);
    rd(`RTCIA_OFS_INT_CTRL, `RTCIA_CTRL_RST);
    rd(`RTCIA_OFS_ALARM_DATE, `RTCIA_DATE_RST);
    rd(`RTCIA_OFS_FLAGS, `RTCIA_FLAGS_RST);
    rd(20'hFFFF1, `RTCIA_READ_ZERO);
    wr(`RTCIA_OFS_INT_CTRL, 8'hFF);
    rd(`RTCIA_OFS_INT_CTRL, 8'hEC);
    rnd = 8'($urandom);
    wr(`RTCIA_OFS_ALARM_DATE, rnd);
    rd(`RTCIA_OFS_ALARM_DATE, rnd & 8'hBF);
    wr(`RTCIA_OFS_ALARM_DATE, 8'h80);
    alarmTimeMatch <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      bitv = 8'h80 >> s;
      wr(`RTCIA_OFS_INT_CTRL, 8'h00);
      fire(s);
      pin(1'b1, 1'b1, 1'b0);
      rd(`RTCIA_OFS_FLAGS, bitv);
      wr(`RTCIA_OFS_FLAGS, 8'hE0);
      wr(`RTCIA_OFS_INT_CTRL, bitv);
      fire(s);
      pin(1'b0, 1'b0, 1'b1);
      rd(`RTCIA_OFS_FLAGS, bitv);
      pin(1'b1, 1'b1, 1'b1);
      wr(`RTCIA_OFS_FLAGS, 8'hE0);
      pin(1'b1, 1'b1, 1'b0);
    end
    wr(`RTCIA_OFS_INT_CTRL, 8'h88);
    fire(0);
    pin(1'b0, 1'b1, 1'b1);
    rd(`RTCIA_OFS_FLAGS, 8'h80);
    pin(1'b0, 1'b0, 1'b1);
    wr(`RTCIA_OFS_FLAGS, 8'hE0);
    wr(`RTCIA_OFS_INT_CTRL, 8'h8C);
    actCnt = 0;
    fire(0);
    idle(20);
    cmp("pulse cycles", 8'h08, 8'(actCnt));
    wr(`RTCIA_OFS_FLAGS, 8'hE0);
    wr(`RTCIA_OFS_INT_CTRL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`RTCIA_OFS_ALARM_DATE, dates[k]);
      curDateTens <= curs[k][5:4];
      curDateUnits <= curs[k][3:0];
      fire(1);
      rd(`RTCIA_OFS_FLAGS, hits[k]);
      wr(`RTCIA_OFS_FLAGS, 8'hE0);
    end
    // A timeout in the very cycle of a clearing write keeps its flag.
    wdogTimeoutStb <= 1'b1;
    host.bus(1'b1, 1'b0, `RTCIA_OFS_FLAGS, 8'hE0);
    wdogTimeoutStb <= 1'b0;
    idle(1);
    rd(`RTCIA_OFS_FLAGS, 8'h80);
    wr(`RTCIA_OFS_FLAGS, 8'hE0);
    // An alarm instant without a time match sets nothing.
    alarmTimeMatch <= 1'b0;
    fire(1);
    rd(`RTCIA_OFS_FLAGS, 8'h00);
    // A second reset in mid-run returns the pin and the alarm date register to rest.
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pin(1'b1, 1'b1, 1'b0);
    rd(`RTCIA_OFS_ALARM_DATE, `RTCIA_DATE_RST);
    idle(2);
    close_out();
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
endmodule
